// >>> verilog/eeprom_pkg.sv
// ----------------------------------------------------------------
// Shared constants and types
// ----------------------------------------------------------------
package eeprom_pkg;

    // Array geometry
    localparam int ADDR_W = 11; // Full byte address width
    localparam int BYTE_W = 8; // Data byte width
    localparam int BLK_W = 3; // Block select width
    localparam int PAGE_W = 5; // In-page offset width
    localparam int MEM_DEPTH = 2048; // Bytes in the array
    localparam int PAGE_BYTES = 32; // Bytes in one page
    localparam int ENTRY_W = ADDR_W + BYTE_W; // Buffered address plus data

    // Slave address byte layout
    localparam logic [3:0] DEV_CODE = 4'h5; // Type code; value is arbitrary
    localparam int CODE_MSB = 7; // Type code top bit
    localparam int CODE_LSB = 4; // Type code bottom bit
    localparam int BLK_MSB = 3; // Block select top bit
    localparam int BLK_LSB = 1; // Block select bottom bit
    localparam int DIR_BIT = 0; // Direction bit, one means read

    // Bit counting inside a byte
    localparam logic [3:0] BIT_LAST = 4'h7; // Eighth bit of a byte
    localparam logic [2:0] BIT_TOP = 3'h7; // Index of the first bit sent
    localparam logic SDA_LOW = 1'b0; // Open-drain pin only pulls low

    // Program cycle timing
    localparam int CLK_HZ = 10_000_000; // System clock rate
    localparam int T_EW_MS = 10; // Longest program cycle in ms
    localparam int EW_CYCLES = T_EW_MS * (CLK_HZ / 1000); // Rounded down
    localparam int EW_CNT_W = $clog2(EW_CYCLES + 1); // Timer width

    // Bus side states
    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_DEV = 7'h02,
        S_WORD = 7'h04,
        S_DATA = 7'h08,
        S_ACK = 7'h10,
        S_TX = 7'h20,
        S_MACK = 7'h40
    } bus_state_t;

    // Programming engine states
    typedef enum logic [2:0] {
        P_IDLE = 3'h1,
        P_DRAIN = 3'h2,
        P_WAIT = 3'h4
    } prog_state_t;

endpackage

// >>> verilog/pin_sync.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ----------------------------------------------------------------
module pin_sync #(
    parameter int W = 3 // Number of pins
) (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic [W-1:0] d_in, // Asynchronous pins
    output logic [W-1:0] q_out // Synchronised copy
);

    logic [W-1:0] meta_reg; // First stage, read only by second

    // Both stages reset to the idle-high bus level
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_reg <= '1;
            q_out <= '1;
        end else begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end

endmodule

// >>> verilog/page_fifo.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Flip-flop FIFO with valid and ready on both sides
// ----------------------------------------------------------------
module page_fifo #(
    parameter int W = 19, // Word width
    parameter int D = 32 // Depth in words
) (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic in_valid, // Word offered
    output logic in_ready, // Room for a word
    input wire logic [W-1:0] in_data, // Offered word
    output logic out_valid, // Word available
    input wire logic out_ready, // Drain takes the word
    output logic [W-1:0] out_data // Oldest word
);

    localparam int PW = $clog2(D); // Pointer width
    localparam int CW = $clog2(D + 1); // Count width

    logic [W-1:0] mem_reg [0:D-1]; // Storage
    logic [PW-1:0] wr_ptr_reg; // Next slot to fill
    logic [PW-1:0] rd_ptr_reg; // Oldest slot
    logic [CW-1:0] count_reg; // Words held
    logic do_push; // Write this cycle
    logic do_pop; // Read this cycle

    // Honest flags from the word count
    assign in_ready = count_reg != CW'(D);
    assign out_valid = count_reg != '0;
    assign out_data = mem_reg[rd_ptr_reg];
    assign do_push = in_valid && in_ready;
    assign do_pop = out_valid && out_ready;

    // Storage write
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers wrap at the depth
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(D - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(D - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
        end
    end

    // Occupancy
    always_ff @(posedge clk) begin
        if (reset) begin
            count_reg <= '0;
        end else if (do_push && !do_pop) begin
            count_reg <= count_reg + 1'b1;
        end else if (do_pop && !do_push) begin
            count_reg <= count_reg - 1'b1;
        end
    end

endmodule

// >>> verilog/eeprom_access.sv
`timescale 1ns/100ps
// How it works
// R01: Answer only when type code matches.
// R02: Address bits B3..B1 select block, top bits.
// R03: Lowest address bit one means read.
// R04: Acknowledge word address, then data bytes.
// R05: Advance address after each written byte.
// R06: STOP starts program cycle, ten ms max.
// R07: No acknowledge while programming.
// R08: Ignore bus entirely while programming.
// R09: Accept up to 32 bytes per page.
// R10: Writes increment low five bits only.
// R11: Master sends at most 32 bytes.
// R12: Write only while protect input low.
// R13: Protected: address acked, data not acked.
// R14: Current, random and sequential reads supported.
// R15: Reads increment full address, wrap to zero.
// R16: Master nack ends read, release line.
// R17: Writes limited, reads unlimited in length.
// R18: Random read via repeated start; retained address.
// R19: Reset clears; START or STOP aborts transfer.
module eeprom_access
    import eeprom_pkg::*;
#(
    parameter int EW_CYCLES_P = EW_CYCLES // Program cycle length in clocks
) (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic scl_in, // Bus clock pin
    input wire logic sda_in, // Bus data pin level
    output logic sda_out, // Bus data drive value
    output logic sda_oe, // Bus data pulled low when high
    input wire logic wp_in, // Write protect pin, high protects
    output logic write_busy // Program cycle running
);
    // ----------------------------------------------------------------
    // Pin sampling and bus conditions
    // ----------------------------------------------------------------
    logic [2:0] pins_s; // Synchronised scl, sda, wp
    logic scl_s; // Clock level
    logic sda_s; // Data level
    logic wp_s; // Protect level
    logic scl_prev_reg; // Clock one cycle ago
    logic sda_prev_reg; // Data one cycle ago
    logic rise; // Clock rising edge
    logic fall; // Clock falling edge
    logic start_c; // START seen
    logic stop_c; // STOP seen
    pin_sync #(.W(3)) pin_sync_inst (
        .clk(clk),
        .reset(reset),
        .d_in({scl_in, sda_in, wp_in}),
        .q_out(pins_s)
    );
    assign scl_s = pins_s[2];
    assign sda_s = pins_s[1];
    assign wp_s = pins_s[0];
    // Previous levels for edge finding
    always_ff @(posedge clk) begin
        if (reset) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
        end
    end
    assign rise = scl_s && !scl_prev_reg;
    assign fall = !scl_s && scl_prev_reg;
    assign start_c = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
    assign stop_c = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
    // ----------------------------------------------------------------
    // Address arithmetic
    // ----------------------------------------------------------------
    // Write increment stays inside the page
    function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
        page_inc = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 1'b1};
    endfunction
    // Read increment runs over the whole array
    function automatic logic [ADDR_W-1:0] lin_inc(input logic [ADDR_W-1:0] a);
        lin_inc = a + 1'b1;
    endfunction
    // ----------------------------------------------------------------
    // State and storage
    // ----------------------------------------------------------------
    bus_state_t state_reg; // Bus side state
    bus_state_t ack_ret_reg; // State after the ack slot
    prog_state_t prog_reg; // Programming engine state
    logic ack_flag_reg; // Pull low in ack slot
    logic ack_phase_reg; // Ack slot entered
    logic [3:0] bit_cnt_reg; // Bits of current byte
    logic [6:0] shift_reg; // Bits received so far
    logic [BLK_W-1:0] block_reg; // Block from slave address
    logic [ADDR_W-1:0] addr_reg; // Internal word address
    logic drive_low_reg; // Pull data low
    logic pend_reg; // Data bytes buffered
    logic [EW_CNT_W-1:0] ew_cnt_reg; // Program cycle timer
    logic [BYTE_W-1:0] mem_reg [0:MEM_DEPTH-1]; // Array
    logic [BYTE_W-1:0] rx_byte; // Byte completing now
    logic [BYTE_W-1:0] rd_byte; // Byte at the address
    logic byte_done; // Eighth bit clocked in
    logic busy; // Program cycle running
    logic live; // Bus events allowed
    logic addr_match; // Type code matches
    logic push_req; // Data byte to buffer
    logic fifo_in_ready; // Buffer has room
    logic fifo_out_valid; // Buffer holds a byte
    logic fifo_out_ready; // Engine drains
    logic [ENTRY_W-1:0] fifo_out_data; // Address and byte
    assign rx_byte = {shift_reg, sda_s};
    assign rd_byte = mem_reg[addr_reg];
    assign byte_done = rise && bit_cnt_reg == BIT_LAST;
    assign busy = prog_reg != P_IDLE;
    assign live = !busy && !start_c && !stop_c;
    assign addr_match = rx_byte[CODE_MSB:CODE_LSB] == DEV_CODE; // R01
    assign push_req = live && state_reg == S_DATA && byte_done && !wp_s; // R12
    assign fifo_out_ready = prog_reg == P_DRAIN;
    assign sda_out = SDA_LOW;
    assign sda_oe = drive_low_reg;
    assign write_busy = busy;
    // ----------------------------------------------------------------
    // Bus side state machine
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= S_IDLE; // R19
            ack_ret_reg <= S_IDLE;
            ack_flag_reg <= 1'b0;
            ack_phase_reg <= 1'b0;
        end else if (busy) begin
            state_reg <= S_IDLE; // R08 R07
        end else if (start_c) begin
            state_reg <= S_DEV; // R19 R18
        end else if (stop_c) begin
            state_reg <= S_IDLE; // R19
        end else begin
            case (state_reg)
                // Slave address byte
                S_DEV: begin
                    if (byte_done) begin
                        if (addr_match) begin
                            state_reg <= S_ACK;
                            ack_flag_reg <= 1'b1;
                            ack_phase_reg <= 1'b0;
                            // Read goes straight to sending
                            ack_ret_reg <= rx_byte[DIR_BIT] ? S_TX : S_WORD; // R03 R14
                        end else begin
                            state_reg <= S_IDLE; // R01
                        end
                    end
                end
                // Word address byte
                S_WORD: begin
                    if (byte_done) begin
                        state_reg <= S_ACK;
                        ack_flag_reg <= 1'b1; // R04 R13
                        ack_phase_reg <= 1'b0;
                        ack_ret_reg <= S_DATA;
                    end
                end
                // Data bytes of a write
                S_DATA: begin
                    if (byte_done) begin
                        state_reg <= S_ACK;
                        // Protected or full buffer is not acked
                        ack_flag_reg <= push_req && fifo_in_ready; // R09 R13 R17
                        ack_phase_reg <= 1'b0;
                        ack_ret_reg <= S_DATA;
                    end
                end
                // Acknowledge slot, two falling edges
                S_ACK: begin
                    if (fall) begin
                        if (!ack_phase_reg) begin
                            ack_phase_reg <= 1'b1;
                        end else begin
                            state_reg <= ack_ret_reg;
                        end
                    end
                end
                // Sending a read byte
                S_TX: begin
                    if (byte_done) begin
                        state_reg <= S_MACK;
                    end
                end
                // Master ack slot, reads never stop on their own
                S_MACK: begin
                    if (rise) begin
                        state_reg <= sda_s ? S_IDLE : S_TX; // R16 R17
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end
    // Bit counter, runs only inside a byte
    always_ff @(posedge clk) begin
        if (reset || (start_c && !busy)) begin
            bit_cnt_reg <= '0; // R19
        end else if (live && rise && state_reg inside {S_DEV, S_WORD, S_DATA, S_TX}) begin
            bit_cnt_reg <= byte_done ? '0 : bit_cnt_reg + 4'h1;
        end
    end
    // Receive shifter
    always_ff @(posedge clk) begin
        if (reset) begin
            shift_reg <= '0;
        end else if (rise) begin
            shift_reg <= rx_byte[BYTE_W-2:0];
        end
    end
    // ----------------------------------------------------------------
    // Data line drive, set on falling clock in ACK and TX, released at once in other states
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            drive_low_reg <= 1'b0;
        end else if (!live) begin
            drive_low_reg <= 1'b0; // R07
        end else begin
            case (state_reg)
                S_ACK: begin
                    if (fall && !ack_phase_reg) begin
                        drive_low_reg <= ack_flag_reg; // R04
                    end else if (fall) begin
                        // Leave the slot, maybe with the first read bit
                        drive_low_reg <= (ack_ret_reg == S_TX) && !rd_byte[BIT_TOP];
                    end
                end
                S_TX: begin
                    if (fall) begin
                        drive_low_reg <= !rd_byte[BIT_TOP - bit_cnt_reg[2:0]];
                    end
                end
                default: begin
                    drive_low_reg <= 1'b0; // R16
                end
            endcase
        end
    end
    // ----------------------------------------------------------------
    // Word address tracking
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            block_reg <= '0;
            addr_reg <= '0;
        end else if (live && byte_done) begin
            if (state_reg == S_DEV && addr_match) begin
                block_reg <= rx_byte[BLK_MSB:BLK_LSB]; // R02
            end else if (state_reg == S_WORD) begin
                addr_reg <= {block_reg, rx_byte}; // R02 R18
            end else if (state_reg == S_DATA && push_req && fifo_in_ready) begin
                addr_reg <= page_inc(addr_reg); // R05 R10 R11
            end else if (state_reg == S_TX) begin
                addr_reg <= lin_inc(addr_reg); // R15
            end
        end
    end
    // ----------------------------------------------------------------
    // Page buffer between bus and array
    // ----------------------------------------------------------------
    page_fifo #(.W(ENTRY_W), .D(PAGE_BYTES)) page_fifo_inst (
        .clk(clk),
        .reset(reset),
        .in_valid(push_req),
        .in_ready(fifo_in_ready),
        .in_data({addr_reg, rx_byte}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );
    // Marks a write that must be programmed at STOP
    always_ff @(posedge clk) begin
        if (reset) begin
            pend_reg <= 1'b0;
        end else if (push_req && fifo_in_ready) begin
            pend_reg <= 1'b1;
        end else if (prog_reg == P_DRAIN) begin
            pend_reg <= 1'b0;
        end
    end
    // ----------------------------------------------------------------
    // Programming engine and its timer
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            prog_reg <= P_IDLE;
            ew_cnt_reg <= '0;
        end else begin
            case (prog_reg)
                P_IDLE: begin
                    if (stop_c && pend_reg) begin
                        prog_reg <= P_DRAIN; // R06
                        ew_cnt_reg <= '0;
                    end
                end
                P_DRAIN: begin
                    ew_cnt_reg <= ew_cnt_reg + 1'b1;
                    if (!fifo_out_valid) begin
                        prog_reg <= P_WAIT;
                    end
                end
                P_WAIT: begin
                    if (ew_cnt_reg >= EW_CNT_W'(EW_CYCLES_P - 1)) begin
                        prog_reg <= P_IDLE; // R06
                    end else begin
                        ew_cnt_reg <= ew_cnt_reg + 1'b1;
                    end
                end
                default: begin
                    prog_reg <= P_IDLE;
                end
            endcase
        end
    end
    // Array write from the buffer
    always_ff @(posedge clk) begin
        if (fifo_out_valid && fifo_out_ready) begin
            mem_reg[fifo_out_data[ENTRY_W-1:BYTE_W]] <= fifo_out_data[BYTE_W-1:0];
        end
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence dev_byte_s;
        live && state_reg == S_DEV && byte_done;
    endsequence
    sequence word_byte_s;
        live && state_reg == S_WORD && byte_done;
    endsequence
    sequence tx_byte_s;
        live && state_reg == S_TX && byte_done;
    endsequence
    sequence write_stop_s;
        prog_reg == P_IDLE && stop_c && pend_reg;
    endsequence
    type_mismatch_a: assert property (dev_byte_s and !addr_match |=> state_reg == S_IDLE) // R01
        else $error("foreign type code not ignored");
    block_select_a: assert property (word_byte_s |=>
        addr_reg[ADDR_W-1:ADDR_W-BLK_W] == $past(block_reg)) // R02
        else $error("block bits not on top of address");
    read_dir_a: assert property (dev_byte_s and addr_match and sda_s |=>
        state_reg == S_ACK && ack_ret_reg == S_TX) // R03
        else $error("read direction not taken");
    page_wrap_a: assert property (push_req && fifo_in_ready |=>
        addr_reg == page_inc($past(addr_reg))) // R10
        else $error("write address left its page");
    read_wrap_a: assert property (tx_byte_s |=> addr_reg == lin_inc($past(addr_reg))) // R15
        else $error("read address not advanced");
    prog_start_a: assert property (write_stop_s |=> prog_reg == P_DRAIN ##1 busy) // R06
        else $error("program cycle not started");
    prog_bound_a: assert property (busy |-> ew_cnt_reg < EW_CNT_W'(EW_CYCLES_P)) // R06
        else $error("program cycle overran");
    busy_silent_a: assert property (busy |=> state_reg == S_IDLE && !sda_oe) // R07 R08
        else $error("bus answered while programming");
    protect_a: assert property (live && state_reg == S_DATA && byte_done && wp_s |=>
        !ack_flag_reg ##0 !pend_reg || $past(pend_reg)) // R12 R13
        else $error("protected byte accepted");
    nack_end_a: assert property (live && state_reg == S_MACK && rise && sda_s |=>
        state_reg == S_IDLE ##1 !sda_oe) // R16
        else $error("line held after master nack");
endmodule

// >>> tb/i2c_master_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Bus master driving clock and data
// ----------------------------------------
module i2c_master_model (
    input wire logic clk, // System clock
    input wire logic sda, // Resolved data wire
    output logic scl, // Bus clock, idle high
    output logic sda_drv // Data drive, one releases
);
    // Idle bus at time zero
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Step just after clock edges
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Start, also repeated start
    task automatic start();
        sda_drv = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(3);
        sda_drv = 1'b0;
        tick(3);
        scl = 1'b0;
        tick(3);
    endtask
    // Stop ends every transfer
    task automatic stop();
        sda_drv = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(3);
        sda_drv = 1'b1;
        tick(3);
    endtask
    // One bit, low 600 ns, high 200 ns
    task automatic bit_io(input logic b, output logic s);
        sda_drv = b;
        tick(5);
        scl = 1'b1;
        tick(1);
        s = sda;
        tick(1);
        scl = 1'b0;
        tick(1);
    endtask
    // Byte out MSB first, returns ack
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = !s;
    endtask
    // Byte in, nack on last byte
    task automatic recv(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, s);
    endtask
endmodule

// >>> tb/eeprom_access_tb.sv
`timescale 1ns/100ps
module eeprom_access_tb;
    import eeprom_pkg::*;
    logic clk, reset, wp, sda_oe, sda_out, busy, scl, sda_drv, a;
    logic [7:0] d;
    int n_errors = 0;
    int num_checks = 0;
    wire sda = (sda_oe ? sda_out : 1'b1) && sda_drv; // Pull-up wire
    // ----------------------------------------
    // Clock, devices
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = !clk;
    end
    eeprom_access #(.EW_CYCLES_P(200)) eeprom_access_inst (.clk(clk), .reset(reset),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .wp_in(wp),
        .write_busy(busy));
    i2c_master_model i2c_master_model_inst (.clk(clk), .sda(sda), .scl(scl),
        .sda_drv(sda_drv));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Address phase, optional switch to read
    task automatic addr(input logic [2:0] blk, input logic [7:0] wa, input logic rd);
        i2c_master_model_inst.start();
        i2c_master_model_inst.send({DEV_CODE, blk, 1'b0}, a);
        chk(a, 1);
        i2c_master_model_inst.send(wa, a);
        chk(a, 1);
        if (rd) begin
            i2c_master_model_inst.start();
            i2c_master_model_inst.send({DEV_CODE, blk, 1'b1}, a);
            chk(a, 1);
        end
    endtask
    // Program cycle must end in bounds
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy === 1'b1 && n < 400) begin
            i2c_master_model_inst.tick(1);
            n++;
        end
        chk(n <= 200, 1);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_write();
        addr(3'h0, 8'h1f, 0);
        i2c_master_model_inst.send(8'ha1, a);
        chk(a, 1);
        i2c_master_model_inst.send(8'hb2, a);
        chk(a, 1);
        i2c_master_model_inst.send(8'hc3, a);
        chk(a, 1);
        i2c_master_model_inst.stop();
        i2c_master_model_inst.tick(6);
        chk(busy, 1);
        i2c_master_model_inst.start();
        i2c_master_model_inst.send({DEV_CODE, 3'h0, 1'b0}, a);
        chk(a, 0);
        i2c_master_model_inst.stop();
        wait_idle();
        addr(3'h7, 8'hff, 0);
        i2c_master_model_inst.send(8'hd4, a);
        chk(a, 1);
        i2c_master_model_inst.stop();
        i2c_master_model_inst.tick(6);
        wait_idle();
        $display("test write done");
    endtask
    task automatic t_read();
        addr(3'h7, 8'hff, 1);
        i2c_master_model_inst.recv(0, d);
        chk(d, 8'hd4);
        i2c_master_model_inst.recv(1, d);
        chk(d, 8'hb2);
        i2c_master_model_inst.stop();
        i2c_master_model_inst.start();
        i2c_master_model_inst.send({DEV_CODE, 3'h0, 1'b1}, a);
        chk(a, 1);
        i2c_master_model_inst.recv(1, d);
        chk(d, 8'hc3);
        i2c_master_model_inst.stop();
        $display("test read done");
    endtask
    task automatic t_protect();
        wp = 1'b1;
        addr(3'h7, 8'hff, 0);
        i2c_master_model_inst.send(8'h00, a);
        chk(a, 0);
        i2c_master_model_inst.stop();
        i2c_master_model_inst.tick(6);
        chk(busy, 0);
        wp = 1'b0;
        addr(3'h7, 8'hff, 1);
        i2c_master_model_inst.recv(1, d);
        chk(d, 8'hd4);
        i2c_master_model_inst.stop();
        i2c_master_model_inst.start();
        i2c_master_model_inst.send({~DEV_CODE, 3'h0, 1'b1}, a);
        chk(a, 0);
        i2c_master_model_inst.stop();
        $display("test protect done");
    endtask
    // ----------------------------------------
    // Verdict, sequence, watchdog
    // ----------------------------------------
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        reset = 1'b1;
        wp = 1'b0;
        repeat (3) @(posedge clk);
        #1 reset = 1'b0;
        i2c_master_model_inst.tick(3);
        t_write();
        t_read();
        t_protect();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        test_done();
    end
endmodule
